// [src/qcs_pkg.sv]
package qcs_pkg;

	// queue codes, highest priority first
	localparam logic [1:0] Q_HIGH   = 2'h0;
	localparam logic [1:0] Q_MIDDLE = 2'h1;
	localparam logic [1:0] Q_LOW    = 2'h2;
	localparam logic [1:0] Q_LOWEST = 2'h3;
	localparam int         QUEUES   = 4;

	// weighted round credits, one nibble per queue: 8,4,2,1
	localparam logic [15:0] WEIGHTS = 16'h1248;

	// queue depth and occupancy width
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W      = 4;

	// priority type selections
	localparam logic [2:0] TYPE_DISABLE   = 3'h0;
	localparam logic [2:0] TYPE_PORT      = 3'h1;
	localparam logic [2:0] TYPE_TOS_ONLY  = 3'h2;
	localparam logic [2:0] TYPE_COS_ONLY  = 3'h3;
	localparam logic [2:0] TYPE_TOS_FIRST = 3'h4;
	localparam logic [2:0] TYPE_COS_FIRST = 3'h5;

	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_PORTMAP = 8'h04;
	localparam logic [7:0] REG_COSMAP  = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0C;
	localparam logic [7:0] REG_TOSMAP0 = 8'h10;
	localparam logic [7:0] REG_TOSMAP3 = 8'h1C;

	// control fields
	localparam int CTRL_STRICT_BIT = 0;
	localparam int CTRL_TYPE_LSB   = 4;

	// reset values: every map entry selects the lowest queue
	localparam logic        CTRL_STRICT_RESET = 1'h0;
	localparam logic [2:0]  CTRL_TYPE_RESET   = 3'h0;
	localparam logic [15:0] PORTMAP_RESET     = 16'hFFFF;
	localparam logic [15:0] COSMAP_RESET      = 16'hFFFF;
	localparam logic [127:0] TOSMAP_RESET     = 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;

	// frame descriptor from an ingress port
	typedef struct packed {
		logic [2:0] port;    // ingress port 0..7
		logic       hasVlan; // frame carries a vlan tag
		logic [2:0] cos;     // class of service from the tag
		logic       isIp;    // frame is an ip packet
		logic [5:0] tos;     // type of service value
		logic [7:0] tag;     // buffer handle of the frame
	} qcs_desc_t;

	// frame handed to the egress transmitter
	typedef struct packed {
		logic [1:0] queue;
		qcs_desc_t  desc;
	} qcs_out_t;

	// index of the lowest set bit, i.e. highest priority candidate
	function automatic logic [1:0] first_set(input logic [3:0] v);
		logic [1:0] idx;
		idx = 2'h3;
		for (int i = 3; i >= 0; i--)
			if (v[i])
				idx = 2'(i);
		return idx;
	endfunction

endpackage

// [src/qcs_fifo.sv]
`timescale 1ns/1ps
module qcs_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 8
) (
	input  wire logic                       ref_clk,  // switch clock
	input  wire logic                       rst,      // sync reset
	input  wire logic                       inValid,  // write request
	output logic                            inReady,  // space left
	input  wire logic [WIDTH-1:0]           inData,   // write word
	output logic                            outValid, // word available
	input  wire logic                       outReady, // read request
	output logic [WIDTH-1:0]                outData,  // head word
	output logic [$clog2(DEPTH+1)-1:0]      count     // occupancy
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic             push;
	logic             pop;

	// honest full and empty from the occupancy
	assign inReady  = (count != ($clog2(DEPTH+1))'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// storage
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	// pointers and occupancy
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// [src/qcs_classify.sv]
`timescale 1ns/1ps
module qcs_classify (
	input  wire qcs_pkg::qcs_desc_t desc,     // frame to classify
	input  wire logic [2:0]         prioType, // selected priority type
	input  wire logic [15:0]        portMap,  // 2 bits per port
	input  wire logic [15:0]        cosMap,   // 2 bits per cos value
	input  wire logic [127:0]       tosMap,   // 2 bits per tos value
	output logic [1:0]              queue     // chosen queue
);
	logic [1:0] portQ;
	logic [1:0] cosQ;
	logic [1:0] tosQ;

	// table lookups
	assign portQ = portMap[{desc.port, 1'b0} +: 2];
	assign cosQ  = cosMap[{desc.cos, 1'b0} +: 2];
	assign tosQ  = tosMap[{desc.tos, 1'b0} +: 2];

	// selection by priority type, unusable frames fall to lowest
	always_comb
	begin
		queue = qcs_pkg::Q_LOWEST;
		case (prioType)
			qcs_pkg::TYPE_PORT:
				queue = portQ;
			qcs_pkg::TYPE_TOS_ONLY:
				if (desc.isIp)
					queue = tosQ;
			qcs_pkg::TYPE_COS_ONLY:
				if (desc.hasVlan)
					queue = cosQ;
			qcs_pkg::TYPE_TOS_FIRST:
				if (desc.isIp)
					queue = tosQ;
				else if (desc.hasVlan)
					queue = cosQ;
			qcs_pkg::TYPE_COS_FIRST:
				if (desc.hasVlan)
					queue = cosQ;
				else if (desc.isIp)
					queue = tosQ;
			default:
				queue = qcs_pkg::Q_LOWEST;
		endcase
	end
endmodule

// [src/qcs_top.sv]
// What this block does
// - weighted mode serves 8:4:2:1, skipping empties
// - strict mode serves highest non-empty queue
// - five priority types plus disabled setting
// - port-based: queue from per-port setting
// - cos values 0..7 map to queues
// - tos values 0..63 map to queues
// - tos table resets to lowest queue
// - ip packet queued by its tos entry in tos-only and tos-first types, and in cos-first without a vlan tag
`timescale 1ns/1ps
module qcs_top #(
	parameter int DEPTH = 8
) (
	input  wire logic               ref_clk,   // switch clock, 20 MHz
	input  wire logic               rst,       // sync reset, active high
	input  wire logic               hsel,      // ahb slave select
	input  wire logic [31:0]        haddr,     // ahb address
	input  wire logic [1:0]         htrans,    // ahb transfer type
	input  wire logic               hwrite,    // ahb write
	input  wire logic [2:0]         hsize,     // ahb size, word only
	input  wire logic [31:0]        hwdata,    // ahb write data
	input  wire logic               hready,    // ahb bus ready
	output logic                    hreadyout, // ahb slave ready
	output logic [31:0]             hrdata,    // ahb read data
	output logic                    hresp,     // ahb response, okay
	input  wire logic               inValid,   // ingress frame offered
	output logic                    inReady,   // ingress frame taken
	input  wire qcs_pkg::qcs_desc_t inDesc,    // ingress descriptor
	output logic                    outValid,  // egress frame offered
	input  wire logic               outReady,  // egress frame taken
	output qcs_pkg::qcs_out_t       outFrame   // egress frame and queue
);
	localparam int DW = $bits(qcs_pkg::qcs_desc_t);
	localparam int CW = $clog2(DEPTH+1);

	// configuration
	logic         strictMode;
	logic [2:0]   prioType;
	logic [15:0]  portMap;
	logic [15:0]  cosMap;
	logic [127:0] tosMap;

	// bus data phase
	logic         wrPend;
	logic [7:0]   wrAddr;
	logic         busTake;

	// ingress stage
	logic               stageValid;
	qcs_pkg::qcs_desc_t stageDesc;
	logic [1:0]         stageQ;
	logic [1:0]         classQ;
	logic               accept;
	logic               pushDone;
	logic               next_stageValid;

	// queues
	logic [3:0]         qInValid;
	logic [3:0]         qInReady;
	logic [3:0]         qOutValid;
	logic [3:0]         qOutReady;
	qcs_pkg::qcs_desc_t qOutData [4];
	logic [CW-1:0]      qCount [4];

	// scheduler
	logic [3:0]  credit [4];
	logic [3:0]  eligible;
	logic        slotFree;
	logic        pickValid;
	logic [1:0]  pickQ;
	logic        reload;
	logic        pop;

	// register read decode, used by the read path when no write is forwarded
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			qcs_pkg::REG_CTRL:
			begin
				d[qcs_pkg::CTRL_STRICT_BIT] = strictMode;
				d[qcs_pkg::CTRL_TYPE_LSB +: 3] = prioType;
			end
			qcs_pkg::REG_PORTMAP:
				d[15:0] = portMap;
			qcs_pkg::REG_COSMAP:
				d[15:0] = cosMap;
			qcs_pkg::REG_STATUS:
				d[15:0] = {qCount[3][3:0], qCount[2][3:0], qCount[1][3:0], qCount[0][3:0]};
			default:
				if (a >= qcs_pkg::REG_TOSMAP0 && a <= qcs_pkg::REG_TOSMAP3)
					d = tosMap[{a[3:2], 5'h00} +: 32];
		endcase
		return d;
	endfunction

	// bits that exist in a register, used when a read follows a write
	function automatic logic [31:0] reg_read_mask(input logic [7:0] a);
		logic [31:0] m;
		m = 32'h0000_0000;
		case (a)
			qcs_pkg::REG_CTRL:
				m = 32'h0000_0071;
			qcs_pkg::REG_PORTMAP, qcs_pkg::REG_COSMAP:
				m = 32'h0000_FFFF;
			default:
				if (a >= qcs_pkg::REG_TOSMAP0 && a <= qcs_pkg::REG_TOSMAP3)
					m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction

	assign busTake = hsel && htrans[1] && hready;

	// address phase capture and read data, zero wait states
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wrPend    <= 1'b0;
			wrAddr    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			wrPend <= busTake && hwrite;
			wrAddr <= {haddr[7:2], 2'b00};
			if (busTake && !hwrite)
			begin
				if (wrPend && wrAddr == {haddr[7:2], 2'b00} && wrAddr != qcs_pkg::REG_STATUS)
					hrdata <= hwdata & reg_read_mask(wrAddr);
				else
					hrdata <= reg_read({haddr[7:2], 2'b00});
			end
		end
	end

	// register writes in the data phase
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			strictMode <= qcs_pkg::CTRL_STRICT_RESET;
			prioType   <= qcs_pkg::CTRL_TYPE_RESET;
			portMap    <= qcs_pkg::PORTMAP_RESET;
			cosMap     <= qcs_pkg::COSMAP_RESET;
			tosMap     <= qcs_pkg::TOSMAP_RESET;
		end
		else if (wrPend)
		begin
			case (wrAddr)
				qcs_pkg::REG_CTRL:
				begin
					strictMode <= hwdata[qcs_pkg::CTRL_STRICT_BIT];
					prioType   <= hwdata[qcs_pkg::CTRL_TYPE_LSB +: 3];
				end
				qcs_pkg::REG_PORTMAP:
					portMap <= hwdata[15:0];
				qcs_pkg::REG_COSMAP:
					cosMap <= hwdata[15:0];
				default:
					if (wrAddr >= qcs_pkg::REG_TOSMAP0 && wrAddr <= qcs_pkg::REG_TOSMAP3)
						tosMap[{wrAddr[3:2], 5'h00} +: 32] <= hwdata;
			endcase
		end
	end

	// classification of the offered frame
	qcs_classify u_classify (
		.desc     (inDesc),
		.prioType (prioType),
		.portMap  (portMap),
		.cosMap   (cosMap),
		.tosMap   (tosMap),
		.queue    (classQ)
	);

	assign accept          = inValid && inReady;
	assign pushDone        = stageValid && qInReady[stageQ];
	assign next_stageValid = (stageValid && !pushDone) || accept;

	// ingress stage holds one frame until its queue has room
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			stageValid <= 1'b0;
			stageDesc  <= '0;
			stageQ     <= qcs_pkg::Q_LOWEST;
			inReady    <= 1'b0;
		end
		else
		begin
			stageValid <= next_stageValid;
			inReady    <= !next_stageValid;
			if (accept)
			begin
				stageDesc <= inDesc;
				stageQ    <= classQ;
			end
		end
	end

	// one queue per priority level
	for (genvar i = 0; i < 4; i++)
	begin : g_queue
		assign qInValid[i]  = stageValid && stageQ == 2'(i);
		assign qOutReady[i] = pop && pickQ == 2'(i);
		qcs_fifo #(
			.WIDTH (DW),
			.DEPTH (DEPTH)
		) u_fifo (
			.ref_clk  (ref_clk),
			.rst      (rst),
			.inValid  (qInValid[i]),
			.inReady  (qInReady[i]),
			.inData   (stageDesc),
			.outValid (qOutValid[i]),
			.outReady (qOutReady[i]),
			.outData  (qOutData[i]),
			.count    (qCount[i])
		);
		assign eligible[i] = qOutValid[i] && credit[i] != 4'h0;
	end

	// pick: strict takes first non-empty, weighted first with credit
	always_comb
	begin
		slotFree  = !outValid || outReady;
		pickValid = 1'b0;
		pickQ     = qcs_pkg::Q_LOWEST;
		reload    = 1'b0;
		if (strictMode)
		begin
			pickValid = |qOutValid;
			pickQ     = qcs_pkg::first_set(qOutValid);
		end
		else
		begin
			pickValid = |eligible;
			pickQ     = qcs_pkg::first_set(eligible);
			reload    = !(|eligible) && (|qOutValid);
		end
		pop = slotFree && pickValid;
	end

	// round credits, refilled once no waiting queue has any left
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 4; i++)
				credit[i] <= qcs_pkg::WEIGHTS[4*i +: 4];
		end
		else if (reload)
		begin
			for (int i = 0; i < 4; i++)
				credit[i] <= qcs_pkg::WEIGHTS[4*i +: 4];
		end
		else if (pop && !strictMode)
			credit[pickQ] <= credit[pickQ] - 4'h1;
	end

	// egress register
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			outValid <= 1'b0;
			outFrame <= '0;
		end
		else if (slotFree)
		begin
			outValid <= pickValid;
			if (pickValid)
				outFrame <= '{queue: pickQ, desc: qOutData[pickQ]};
		end
	end

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_strict_highest: assert property (
		pop && strictMode |-> ((qOutValid & ((4'h1 << pickQ) - 4'h1)) == 4'h0))
		else $error("strict pick skipped a non-empty higher queue");

	a_wrr_credit: assert property (
		pop && !strictMode |-> credit[pickQ] != 4'h0 ##1 credit[$past(pickQ)] == $past(credit[pickQ]) - 4'h1)
		else $error("weighted pick without credit or credit not spent");

	a_wrr_reload: assert property (
		!strictMode && (|qOutValid) && !(|eligible) |=> credit[0] == 4'h8 && credit[1] == 4'h4
			&& credit[2] == 4'h2 && credit[3] == 4'h1)
		else $error("round credits not refilled to 8,4,2,1");

	a_tos_reset: assert property (
		$past(rst) |-> tosMap == qcs_pkg::TOSMAP_RESET)
		else $error("tos table not all lowest after reset");

	a_disabled_lowest: assert property (
		accept && prioType == qcs_pkg::TYPE_DISABLE |=> stageQ == qcs_pkg::Q_LOWEST)
		else $error("frame classified while disabled");

	a_port_queue: assert property (
		accept && prioType == qcs_pkg::TYPE_PORT |=> stageQ == $past(portMap[{inDesc.port, 1'b0} +: 2]))
		else $error("port-based queue mismatch");

	a_tos_queue: assert property (
		accept && inDesc.isIp && (prioType == qcs_pkg::TYPE_TOS_ONLY
			|| prioType == qcs_pkg::TYPE_TOS_FIRST) |=> stageQ == $past(tosMap[{inDesc.tos, 1'b0} +: 2]))
		else $error("ip frame not queued by its tos entry");

	a_cos_queue: assert property (
		accept && inDesc.hasVlan && (prioType == qcs_pkg::TYPE_COS_ONLY
			|| prioType == qcs_pkg::TYPE_COS_FIRST) |=> stageQ == $past(cosMap[{inDesc.cos, 1'b0} +: 2]))
		else $error("tagged frame not queued by its cos entry");

	a_fallback_order: assert property (
		accept && prioType == qcs_pkg::TYPE_TOS_FIRST && !inDesc.isIp && inDesc.hasVlan
			|=> stageQ == $past(cosMap[{inDesc.cos, 1'b0} +: 2]))
		else $error("tos-first did not fall back to cos table");

	a_cos_fallback: assert property (
		accept && prioType == qcs_pkg::TYPE_COS_FIRST && !inDesc.hasVlan && inDesc.isIp
			|=> stageQ == $past(tosMap[{inDesc.tos, 1'b0} +: 2]))
		else $error("cos-first did not fall back to tos table");

	a_unusable_lowest: assert property (
		accept && prioType == qcs_pkg::TYPE_TOS_ONLY && !inDesc.isIp |=> stageQ == qcs_pkg::Q_LOWEST)
		else $error("non-ip frame under tos-only not sent to lowest queue");

	a_out_hold: assert property (
		outValid && !outReady |=> outValid && $stable(outFrame))
		else $error("egress frame changed while stalled");

	c_strict_low: cover property (pop && strictMode && pickQ == qcs_pkg::Q_LOWEST);
	c_wrr_reload: cover property (reload ##1 pop);
	c_queue_full: cover property (stageValid && !qInReady[stageQ]);
	c_tos_first: cover property (accept && prioType == qcs_pkg::TYPE_TOS_FIRST);
	c_port_based: cover property (accept && prioType == qcs_pkg::TYPE_PORT);
endmodule

// [bench/qcs_egress_sink.sv]
`timescale 1ns/1ps
// far-side transmitter taking egress frames, promptly or with random stalls
module qcs_egress_sink (
	input  wire logic ref_clk,  // switch clock
	input  wire logic rst,      // sync reset
	input  wire logic stall,    // hold off every take
	input  wire logic prompt,   // take every offer at once
	output logic      outReady  // frame taken
);
	logic [7:0] lfsr;

	// ready pattern only changes just after an edge
	always_ff @(posedge ref_clk)
	begin
		lfsr <= rst ? 8'h5A : {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		outReady <= !rst && !stall && (prompt || lfsr[0]);
	end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic               ref_clk;
	logic               rst;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [2:0]         hsize;
	logic [31:0]        hwdata;
	logic               hreadyout;
	logic [31:0]        hrdata;
	logic               hresp;
	logic               inValid;
	logic               inReady;
	qcs_pkg::qcs_desc_t inDesc;
	logic               outValid;
	logic               outReady;
	qcs_pkg::qcs_out_t  outFrame;
	logic               stall;
	logic               prompt;
	logic [31:0]        seed;
	logic [15:0]        pm;
	logic [15:0]        cm;
	logic [127:0]       tm;
	int                 mismatches;
	int                 total_checks;
	qcs_pkg::qcs_out_t  expq[$];

	qcs_top #(.DEPTH(8)) qcs_top_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .inValid(inValid),
		.inReady(inReady), .inDesc(inDesc), .outValid(outValid), .outReady(outReady),
		.outFrame(outFrame));
	qcs_egress_sink qcs_egress_sink_inst (.ref_clk(ref_clk), .rst(rst), .stall(stall),
		.prompt(prompt), .outReady(outReady));

	// clock
	initial
	begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	// xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// reference classification from the current map copies
	function automatic logic [1:0] cls(input logic [2:0] t, input qcs_pkg::qcs_desc_t d);
		logic [1:0] tq;
		logic [1:0] cq;
		tq = d.isIp ? tm[2*d.tos +: 2] : 2'h3;
		cq = d.hasVlan ? cm[2*d.cos +: 2] : 2'h3;
		case (t)
			qcs_pkg::TYPE_PORT:      return pm[2*d.port +: 2];
			qcs_pkg::TYPE_TOS_ONLY:  return tq;
			qcs_pkg::TYPE_COS_ONLY:  return cq;
			qcs_pkg::TYPE_TOS_FIRST: return d.isIp ? tq : cq;
			qcs_pkg::TYPE_COS_FIRST: return d.hasVlan ? cq : tq;
			default:                 return 2'h3;
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", name, want, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'h1, a, d, x);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		logic [31:0] x;
		ahb(1'h0, a, 32'h0, x);
		check("register", x, want);
	endtask

	// offer one descriptor and hold it until taken
	task automatic send(input qcs_pkg::qcs_desc_t d);
		@(posedge ref_clk);
		inValid <= 1'h1;
		inDesc <= d;
		do @(posedge ref_clk); while (inReady !== 1'h1);
		inValid <= 1'h0;
	endtask

	task automatic drain();
		for (int k = 0; k < 600 && expq.size() != 0; k++)
			@(posedge ref_clk);
		check("frames left", expq.size(), 32'h0);
	endtask

	task automatic do_reset();
		rst <= 1'h1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		pm = 16'hFFFF;
		cm = 16'hFFFF;
		tm = '1;
	endtask

	// fill queue 0 and put three frames in each other queue with egress stalled, then release and follow the policy
	task automatic sched(input logic strictMode);
		logic [31:0]        r;
		int                 qs[4][$];
		int                 cr[4];
		int                 p;
		qcs_pkg::qcs_desc_t d[19];
		do_reset();
		stall <= 1'h1;
		wr(qcs_pkg::REG_PORTMAP, 32'h0000_00E4);
		pm = 16'h00E4;
		wr(qcs_pkg::REG_CTRL, {25'h0, qcs_pkg::TYPE_PORT, 3'h0, strictMode});
		for (int i = 0; i < 19; i++)
		begin
			r = rnd();
			d[i] = r[21:0];
			d[i].port = (i == 0 || i > 9) ? 3'h0 : 3'((i - 1) / 3 + 1);
			d[i].tag = 8'(i);
			send(d[i]);
			if (i > 0)
				qs[d[i].port].push_back(i);
		end
		repeat (4) @(posedge ref_clk);
		check("inReady full", {31'h0, inReady}, 32'h0);
		rdchk(qcs_pkg::REG_STATUS, 32'h0000_3338);
		expq.push_back({2'h0, d[0]});
		cr = '{7, 4, 2, 1};
		while (qs[0].size() + qs[1].size() + qs[2].size() + qs[3].size() > 0)
		begin
			p = -1;
			for (int q = 3; q >= 0; q--)
				if (qs[q].size() > 0 && (strictMode || cr[q] > 0))
					p = q;
			if (p < 0)
				cr = '{8, 4, 2, 1};
			else
			begin
				cr[p]--;
				expq.push_back({2'(p), d[qs[p].pop_front()]});
			end
		end
		stall <= 1'h0;
		drain();
	endtask

	// every type code, four frames on the maps left from before, then random maps
	task automatic classify_all();
		logic [31:0]        r;
		logic [2:0]         t;
		qcs_pkg::qcs_desc_t d;
		prompt <= 1'h1;
		for (int i = 0; i < 8; i++)
		begin
			t = 3'(i + 2);
			r = rnd();
			wr(qcs_pkg::REG_CTRL, {25'h0, t, 3'h0, r[0]});
			for (int n = 0; n < 16; n++)
			begin
				if (n == 4)
				begin
					pm = 16'(rnd());
					cm = 16'(rnd());
					wr(qcs_pkg::REG_PORTMAP, {16'h0, pm});
					wr(qcs_pkg::REG_COSMAP, {16'h0, cm});
					for (int w = 0; w < 4; w++)
					begin
						tm[32*w +: 32] = rnd();
						wr(8'(qcs_pkg::REG_TOSMAP0 + 4 * w), tm[32*w +: 32]);
					end
				end
				r = rnd();
				d = r[21:0];
				expq.push_back({cls(t, d), d});
				send(d);
				drain();
			end
		end
	endtask

	// egress monitor against the reference order
	always @(posedge ref_clk)
		if (outValid === 1'h1 && outReady === 1'h1)
		begin
			if (expq.size() == 0)
				check("spare frame", 32'h1, 32'h0);
			else
				check("egress frame", 32'(outFrame), 32'(expq.pop_front()));
		end

	// hang guard
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		close_out();
	end

	// main sequence
	initial
	begin
		rst = 1'h1;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		inValid = 1'h0;
		inDesc = '0;
		stall = 1'h1;
		prompt = 1'h0;
		seed = 32'hE0F8BC54;
		mismatches = 0;
		total_checks = 0;
		do_reset();
		for (int a = 0; a < 9; a++)
			rdchk(8'(4 * a), (a == 0 || a == 3 || a == 8) ? 32'h0 :
				(a < 3) ? 32'h0000_FFFF : 32'hFFFF_FFFF);
		wr(8'h20, 32'hFFFF_FFFF);
		rdchk(8'h20, 32'h0);
		wr(qcs_pkg::REG_STATUS, 32'hFFFF_FFFF);
		rdchk(qcs_pkg::REG_STATUS, 32'h0);
		wr(qcs_pkg::REG_CTRL, 32'hFFFF_FFFF);
		rdchk(qcs_pkg::REG_CTRL, 32'h0000_0071);
		check("hresp", {31'h0, hresp}, 32'h0);
		check("hreadyout", {31'h0, hreadyout}, 32'h1);
		sched(1'h1);
		sched(1'h0);
		classify_all();
		close_out();
	end
endmodule
